// >>> verilog/cfs_pkg.sv
/*
  Shared constants, types and register map for the status-flag and
  arithmetic core. Assumes one clock at 40 MHz and an AHB-Lite master.
*/
// Contract
// RQ1: after reset only interrupt-disable flag is one
// RQ2: software initialises index and decimal flags
// RQ3: decimal flag makes add/subtract work in BCD
// RQ4: software waits one instruction before carry/decimal ops
// RQ5: negative, overflow, zero flags invalid in decimal
// RQ6: multiply and divide ignore index and decimal
// RQ7: multiply and divide leave flag word unchanged
// RQ8: interrupt request write visible after next instruction
// RQ9: software waits one instruction before bit branches
// RQ10: instruction time is cycles times phi period
// RQ11: index flag redirects result to indexed memory
package cfs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS  = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_OPND   = 8'h08;
  localparam logic [7:0] OFS_INDEX  = 8'h0C;
  localparam logic [7:0] OFS_CMD    = 8'h10;
  localparam logic [7:0] OFS_IRQREQ = 8'h14;
  localparam logic [7:0] OFS_HIGH   = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_MEM    = 8'h40;
  localparam int         MEM_DEPTH  = 16;
  localparam int         IDX_W      = 4;

  // ----------------------------------------------------------------
  // processor_flags_word bit positions and reset value
  // ----------------------------------------------------------------
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_I = 2;
  localparam int FL_D = 3;
  localparam int FL_B = 4;
  localparam int FL_T = 5;
  localparam int FL_V = 6;
  localparam int FL_N = 7;
  localparam logic [7:0] FLAGS_RST = 8'h04;

  // status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_NVZ_OK  = 1;
  localparam int ST_REFUSED = 2;

  // ----------------------------------------------------------------
  // timing: phi is CORE_CLK divided down
  // ----------------------------------------------------------------
  localparam int          CORE_CLK_HZ = 40_000_000;
  localparam int          PHI_HZ      = 20_000_000;
  localparam int          PHI_DIV     = CORE_CLK_HZ / PHI_HZ;
  localparam logic [3:0]  PHI_LAST    = 4'(PHI_DIV - 1);
  localparam logic [4:0]  CYC_SIMPLE  = 5'h02;
  localparam logic [4:0]  CYC_T_ALU   = 5'h05;
  localparam logic [4:0]  CYC_MUL     = 5'h0F;
  localparam logic [4:0]  CYC_DIV     = 5'h10;

  // bcd digit correction
  localparam logic [4:0] BCD_MAX = 5'h09;
  localparam logic [4:0] BCD_ADJ = 5'h06;
  localparam logic [4:0] NIB_MAX = 5'h0F;

  localparam logic [2:0] SIZE_WORD = 3'h2;

  typedef enum logic [3:0] {
    OP_NOP, OP_ADC, OP_SUBTRACT_WITH_BORROW, OP_AND, OP_ORA, OP_EOR,
    OP_SET_CARRY, OP_CLEAR_CARRY, OP_SED, OP_CLEAR_BCD, OP_SEI, OP_CLI,
    OP_SET, OP_CLT, OP_PRODUCT, OP_DIV
  } cfs_op_e;

  typedef enum logic {ST_IDLE, ST_EXEC} cfs_state_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } cfs_aph_s;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       v;
  } cfs_alu_s;

endpackage

// >>> verilog/cfs_alu.sv
/*
  Add, subtract and logic unit, binary or decimal.
  Assumes operands stable while its result is used.
*/
`timescale 1ns/1ps
module cfs_alu
  import cfs_pkg::*;
(
  input  wire logic [7:0]       a,
  input  wire logic [7:0]       m,
  input  wire logic             c_in,
  input  wire logic             dec,
  input  cfs_pkg::cfs_op_e      op,
  output cfs_pkg::cfs_alu_s     q
);
  import cfs_pkg::*;

  logic [8:0] bin;
  logic [7:0] mx;
  logic [4:0] lo;
  logic [4:0] hi;

  always_comb begin
    mx  = (op == OP_SUBTRACT_WITH_BORROW) ? ~m : m;
    bin = {1'b0, a} + {1'b0, mx} + {8'h00, c_in};
    lo  = 5'h00;
    hi  = 5'h00;
    q.res = bin[7:0];
    q.c   = bin[8];
    q.v   = ~(a[7] ^ mx[7]) & (a[7] ^ bin[7]);
    case (op)
      OP_ADC: begin
        if (dec) begin                                     // RQ3
          lo = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, c_in};
          if (lo > BCD_MAX) lo = lo + BCD_ADJ;
          hi = {1'b0, a[7:4]} + {1'b0, m[7:4]} + {4'h0, lo > NIB_MAX};
          if (hi > BCD_MAX) hi = hi + BCD_ADJ;
          q.res = {hi[3:0], lo[3:0]};
          q.c   = hi > NIB_MAX;
        end
      end
      OP_SUBTRACT_WITH_BORROW: begin
        if (dec) begin                                     // RQ3
          lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c_in};
          if (lo[4]) lo = lo - BCD_ADJ;
          hi = {1'b0, a[7:4]} - {1'b0, m[7:4]} - {4'h0, lo[4]};
          if (hi[4]) hi = hi - BCD_ADJ;
          q.res = {hi[3:0], lo[3:0]};
          q.c   = ~hi[4];
        end
      end
      OP_AND:  q.res = a & m;
      OP_ORA:  q.res = a | m;
      OP_EOR:  q.res = a ^ m;
      default: q.res = bin[7:0];
    endcase
  end
endmodule

// >>> verilog/cfs_muldiv.sv
/*
  Unsigned 8x8 multiply and 8/8 divide, always binary.
  Divide by zero gives quotient FF and the dividend as remainder.
*/
`timescale 1ns/1ps
module cfs_muldiv (
  input  wire logic [7:0] a,
  input  wire logic [7:0] m,
  input  wire logic       is_div,
  output logic      [7:0] lo,
  output logic      [7:0] hi
);
  logic [15:0] prod;

  always_comb begin
    prod = {8'h00, a} * {8'h00, m};
    lo   = prod[7:0];
    hi   = prod[15:8];
    if (is_div) begin
      if (m == 8'h00) begin
        lo = 8'hFF;
        hi = a;
      end else begin
        lo = a / m;
        hi = a % m;
      end
    end
  end
endmodule

// >>> verilog/cfs_core.sv
/*
  Status-flag and arithmetic core with an AHB-Lite register slave.
  Assumes a single AHB-Lite master, CORE_CLK at 40 MHz, async reset.
*/
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module cfs_core
  import cfs_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic [7:0]  IRQ_EVT,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             BUSY,
  output logic      [7:0]  IRQ_REQ
);
  import cfs_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  function automatic logic [4:0] cycles_of(input cfs_op_e op,
                                           input logic t);
    case (op)
      OP_ADC, OP_SUBTRACT_WITH_BORROW, OP_AND, OP_ORA, OP_EOR:
        cycles_of = t ? CYC_T_ALU : CYC_SIMPLE;
      OP_PRODUCT: cycles_of = CYC_MUL;
      OP_DIV:  cycles_of = CYC_DIV;
      default: cycles_of = CYC_SIMPLE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cfs_aph_s   aph_r,   aph_nxt;
  logic [31:0] rdata_nxt;
  logic [7:0] acc_r,   acc_nxt;
  logic [7:0] opnd_r,  opnd_nxt;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] high_r,  high_nxt;
  logic [7:0] mem_r   [MEM_DEPTH];
  logic [7:0] mem_nxt [MEM_DEPTH];
  cfs_state_e st_r,    st_nxt;
  cfs_op_e    op_r,    op_nxt;
  logic [4:0] cnt_r,   cnt_nxt;
  logic [3:0] div_r,   div_nxt;
  logic       busy_r,  busy_nxt;
  logic       nvz_r,   nvz_nxt;
  logic       refd_r,  refd_nxt;
  logic [7:0] evt_s1_r;
  logic [7:0] evt_s2_r;
  logic [7:0] req_r,   req_nxt;
  logic [7:0] pend_r,  pend_nxt;
  logic       pw_r,    pw_nxt;
  logic       pgo_r,   pgo_nxt;

  logic       wr_en;
  logic       done;
  logic       phi_tick;
  logic       t_mode;
  logic [7:0] dst;
  logic [7:0] wbyte;
  cfs_alu_s   alu_q;
  logic [7:0] md_lo;
  logic [7:0] md_hi;

  assign wr_en    = aph_r.valid & aph_r.write;
  assign wbyte    = HWDATA[7:0];
  assign phi_tick = (st_r == ST_EXEC) && (div_r == PHI_LAST);
  assign done     = phi_tick && (cnt_r == 5'h01);
  assign t_mode   = flags_r[FL_T];
  assign dst      = t_mode ? mem_r[idx_r] : acc_r;          // RQ11

  cfs_alu u_alu (
    .a    (dst),
    .m    (opnd_r),
    .c_in (flags_r[FL_C]),
    .dec  (flags_r[FL_D]),
    .op   (op_r),
    .q    (alu_q)
  );

  // multiply and divide see acc and operand only, never T or D
  cfs_muldiv u_md (
    .a      (acc_r),                                        // RQ6
    .m      (opnd_r),
    .is_div (op_r == OP_DIV),
    .lo     (md_lo),
    .hi     (md_hi)
  );

  // ----------------------------------------------------------------
  // bus slave: registered read data, never waits
  // ----------------------------------------------------------------
  always_comb begin
    aph_nxt       = '0;
    aph_nxt.valid = HSEL & HTRANS[1] & HREADY & (HSIZE == SIZE_WORD)
                  & (HADDR[31:8] == 24'h000000);
    aph_nxt.write = HWRITE;
    aph_nxt.addr  = {HADDR[7:2], 2'b00};
    rdata_nxt     = 32'h00000000;
    if (aph_nxt.valid && !HWRITE) begin
      case (aph_nxt.addr)
        OFS_FLAGS:  rdata_nxt[7:0] = flags_r;
        OFS_ACC:    rdata_nxt[7:0] = acc_r;
        OFS_OPND:   rdata_nxt[7:0] = opnd_r;
        OFS_INDEX:  rdata_nxt[IDX_W-1:0] = idx_r;
        OFS_CMD:    rdata_nxt[3:0] = op_r;
        OFS_IRQREQ: rdata_nxt[7:0] = req_r;
        OFS_HIGH:   rdata_nxt[7:0] = high_r;
        OFS_STATUS: rdata_nxt[2:0] = {refd_r, nvz_r, busy_r};
        default: begin
          for (int i = 0; i < MEM_DEPTH; i++) begin
            if (hit(aph_nxt.addr, OFS_MEM + 8'(4 * i)))
              rdata_nxt[7:0] = mem_r[i];
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aph_r     <= '0;
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      aph_r     <= aph_nxt;
      HRDATA    <= rdata_nxt;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // instruction sequencing and flag word
  // ----------------------------------------------------------------
  always_comb begin
    acc_nxt   = acc_r;
    opnd_nxt  = opnd_r;
    idx_nxt   = idx_r;
    flags_nxt = flags_r;
    high_nxt  = high_r;
    mem_nxt   = mem_r;
    st_nxt    = st_r;
    op_nxt    = op_r;
    cnt_nxt   = cnt_r;
    nvz_nxt   = nvz_r;
    refd_nxt  = refd_r;
    div_nxt   = (st_r == ST_EXEC) ? div_r + 4'h1 : 4'h0;
    if (phi_tick) begin
      div_nxt = 4'h0;
      cnt_nxt = cnt_r - 5'h01;                              // RQ10
    end
    if (done) begin
      st_nxt = ST_IDLE;
      case (op_r)
        OP_ADC, OP_SUBTRACT_WITH_BORROW: begin
          if (t_mode) mem_nxt[idx_r] = alu_q.res;           // RQ11
          else        acc_nxt = alu_q.res;
          flags_nxt[FL_C] = alu_q.c;
          flags_nxt[FL_V] = alu_q.v;
          flags_nxt[FL_N] = alu_q.res[7];
          flags_nxt[FL_Z] = alu_q.res == 8'h00;
          // decimal results leave N, V and Z meaningless
          nvz_nxt = ~flags_r[FL_D];                         // RQ5
        end
        OP_AND, OP_ORA, OP_EOR: begin
          if (t_mode) mem_nxt[idx_r] = alu_q.res;           // RQ11
          else        acc_nxt = alu_q.res;
          flags_nxt[FL_N] = alu_q.res[7];
          flags_nxt[FL_Z] = alu_q.res == 8'h00;
          nvz_nxt = 1'b1;
        end
        OP_PRODUCT, OP_DIV: begin
          acc_nxt  = md_lo;                                 // RQ7
          high_nxt = md_hi;
        end
        OP_SET_CARRY:   flags_nxt[FL_C] = 1'b1;
        OP_CLEAR_CARRY: flags_nxt[FL_C] = 1'b0;
        OP_SED:         flags_nxt[FL_D] = 1'b1;
        OP_CLEAR_BCD:   flags_nxt[FL_D] = 1'b0;
        OP_SEI: flags_nxt[FL_I] = 1'b1;
        OP_CLI: flags_nxt[FL_I] = 1'b0;
        OP_SET: flags_nxt[FL_T] = 1'b1;
        OP_CLT: flags_nxt[FL_T] = 1'b0;
        default: ;
      endcase
    end
    if (wr_en) begin
      case (aph_r.addr)
        OFS_FLAGS: flags_nxt = wbyte;
        OFS_ACC:   acc_nxt   = wbyte;
        OFS_OPND:  opnd_nxt  = wbyte;
        OFS_INDEX: idx_nxt   = wbyte[IDX_W-1:0];
        OFS_STATUS: refd_nxt = refd_nxt & ~HWDATA[ST_REFUSED];
        OFS_CMD: begin
          // a launch while busy, except in the final cycle, is dropped so the running count holds
          if (st_r == ST_EXEC && !done) begin
            refd_nxt = 1'b1;
          end else begin
            op_nxt  = cfs_op_e'(HWDATA[3:0]);
            cnt_nxt = cycles_of(cfs_op_e'(HWDATA[3:0]), flags_nxt[FL_T]);
            st_nxt  = ST_EXEC;
            div_nxt = 4'h0;
          end
        end
        default: begin
          for (int i = 0; i < MEM_DEPTH; i++) begin
            if (hit(aph_r.addr, OFS_MEM + 8'(4 * i)))
              mem_nxt[i] = wbyte;
          end
        end
      endcase
    end
    busy_nxt = st_nxt == ST_EXEC;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_r   <= 8'h00;
      opnd_r  <= 8'h00;
      idx_r   <= '0;
      flags_r <= FLAGS_RST;                                 // RQ1
      high_r  <= 8'h00;
      for (int i = 0; i < MEM_DEPTH; i++) mem_r[i] <= 8'h00;
      st_r    <= ST_IDLE;
      op_r    <= OP_NOP;
      cnt_r   <= 5'h00;
      div_r   <= 4'h0;
      busy_r  <= 1'b0;
      BUSY    <= 1'b0;
      nvz_r   <= 1'b1;
      refd_r  <= 1'b0;
    end else begin
      acc_r   <= acc_nxt;
      opnd_r  <= opnd_nxt;
      idx_r   <= idx_nxt;
      flags_r <= flags_nxt;
      high_r  <= high_nxt;
      mem_r   <= mem_nxt;
      st_r    <= st_nxt;
      op_r    <= op_nxt;
      cnt_r   <= cnt_nxt;
      div_r   <= div_nxt;
      busy_r  <= busy_nxt;
      BUSY    <= busy_nxt;
      nvz_r   <= nvz_nxt;
      refd_r  <= refd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request bits: writes land after the next instruction
  // ----------------------------------------------------------------
  always_comb begin
    req_nxt  = req_r | evt_s2_r;
    pend_nxt = pend_r;
    pw_nxt   = pw_r;
    pgo_nxt  = pgo_r;
    // a launch in the final cycle of the previous op counts too
    if (pw_r && st_nxt == ST_EXEC && (st_r == ST_IDLE || done))
      pgo_nxt = 1'b1;
    if (done && pgo_r) begin
      // hardware events in this cycle survive the software value
      req_nxt = pend_r | evt_s2_r;                          // RQ8
      pw_nxt  = 1'b0;
      pgo_nxt = 1'b0;
    end
    if (wr_en && hit(aph_r.addr, OFS_IRQREQ)) begin
      pend_nxt = wbyte;                                     // RQ8
      pw_nxt   = 1'b1;
      pgo_nxt  = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      evt_s1_r <= 8'h00;
      evt_s2_r <= 8'h00;
      req_r    <= 8'h00;
      IRQ_REQ  <= 8'h00;
      pend_r   <= 8'h00;
      pw_r     <= 1'b0;
      pgo_r    <= 1'b0;
    end else begin
      evt_s1_r <= IRQ_EVT;
      evt_s2_r <= evt_s1_r;
      req_r    <= req_nxt;
      IRQ_REQ  <= req_nxt;
      pend_r   <= pend_nxt;
      pw_r     <= pw_nxt;
      pgo_r    <= pgo_nxt;
    end
  end

endmodule

// >>> verification/cfs_core_props.sv
/*
  Checker for cfs_core: bus response, instruction timing, request bits.
  Assumes it is bound to the cfs_core ports, one clock domain.
*/
`timescale 1ns/1ps
module cfs_core_props
  import cfs_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        BUSY,
  input wire logic [7:0]  IRQ_REQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // ----------------------------------------------------------------
  // last launched opcode and busy length
  // ----------------------------------------------------------------
  logic       cmd_r,  cmd_nxt;
  logic [3:0] op_r,   op_nxt;
  logic [5:0] len_r,  len_nxt;

  always_comb begin
    cmd_nxt = HSEL && HTRANS[1] && HREADY && HWRITE
              && HSIZE == SIZE_WORD && HADDR == 32'(OFS_CMD);
    // a command written while BUSY is high is treated as refused, so keep the old one
    op_nxt  = (cmd_r && !BUSY) ? HWDATA[3:0] : op_r;
    len_nxt = BUSY ? len_r + 6'h01 : 6'h00;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_r <= 1'b0;
      op_r  <= 4'h0;
      len_r <= 6'h00;
    end else begin
      cmd_r <= cmd_nxt;
      op_r  <= op_nxt;
      len_r <= len_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  busy_min_a: assert property ($rose(BUSY) |-> BUSY[*4])
    else $error("busy shorter than one two-cycle instruction");
  busy_end_a: assert property ($rose(BUSY) |-> ##[4:32] !BUSY)
    else $error("busy longer than the slowest instruction");
  product_len_a: assert property (
    $fell(BUSY) && op_r == OP_PRODUCT |-> len_r == 6'h1E)
    else $error("multiply time not fifteen cycles");
  div_len_a: assert property (
    $fell(BUSY) && op_r == OP_DIV |-> len_r == 6'h20)
    else $error("divide time not sixteen cycles");
  alu_len_a: assert property (
    $fell(BUSY) && op_r inside {OP_ADC, OP_SUBTRACT_WITH_BORROW,
                                OP_AND, OP_ORA, OP_EOR}
    |-> len_r == 6'h04 || len_r == 6'h0A)
    else $error("alu op time wrong");
  simple_len_a: assert property (
    $fell(BUSY) && (op_r == OP_NOP || op_r inside {[OP_SET_CARRY:OP_CLT]})
    |-> len_r == 6'h04)
    else $error("two-cycle op time wrong");
  irq_clear_a: assert property (
    (|($past(IRQ_REQ) & ~IRQ_REQ)) |-> $fell(BUSY))
    else $error("request bit cleared outside instruction end");
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or error response");
  rdata_upper_a: assert property (HRDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  cover property ($fell(BUSY) && op_r == OP_PRODUCT);
  cover property ($fell(BUSY) && op_r == OP_DIV);
  cover property ($fell(BUSY) && len_r == 6'h0A);
  cover property (|($past(IRQ_REQ) & ~IRQ_REQ));
endmodule

bind cfs_core cfs_core_props i_props (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .BUSY(BUSY), .IRQ_REQ(IRQ_REQ)
);

// >>> verification/cfs_core_tb.sv
/*
  Self-checking bench for cfs_core through its AHB-Lite slave.
  Assumes the core is the only slave, so its ready is the bus ready.
*/
`timescale 1ns/1ps
module cfs_core_tb;
  import cfs_pkg::*;

  logic        clk, rst_n, hsel, hwrite, hready, hresp, busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  irq_evt, irq_req;
  int          err_count, num_checks;
  int          fb[4] = '{FL_C, FL_D, FL_I, FL_T};

  cfs_core i_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hready), .IRQ_EVT(irq_evt), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .BUSY(busy), .IRQ_REQ(irq_req)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; returns at the data-phase edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, a, {24'h000000, d}, x);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] mask,
                        input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h00000000, x);
    chk(x & mask, exp);
    chk({31'h0, hresp}, 32'h00000000);
  endtask

  // counts the clocks that busy stands high, bounded
  task automatic wait_idle(input int len);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      if (busy === 1'b1) n++;
    end while (busy !== 1'b0 && n < 40);
    chk(32'(n), 32'(len));
  endtask

  task automatic run(input cfs_op_e op, input int len);
    wr_reg(OFS_CMD, {4'h0, op});
    wait_idle(len);
  endtask

  // c[1] asks for a carry compare, c[0] is the expected carry
  task automatic alu(input logic [7:0] fl, a, m, input cfs_op_e op,
                     input logic [7:0] acc, input logic [1:0] c);
    wr_reg(OFS_FLAGS, fl);
    wr_reg(OFS_ACC, a);
    wr_reg(OFS_OPND, m);
    run(op, 4);
    rd_reg(OFS_ACC, 32'h000000FF, {24'h000000, acc});
    if (c[1]) rd_reg(OFS_FLAGS, 32'h00000001, {31'h0, c[0]});
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] fl;
    rst_n = 1'b0; hsel = 1'b1; htrans = 2'b00; haddr = 32'h0;
    hwrite = 1'b0; hsize = SIZE_WORD; hwdata = 32'h0; irq_evt = 8'h00;
    err_count = 0; num_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({24'h0, irq_req}, 32'h00000000);
    rd_reg(OFS_FLAGS, 32'h00000004, 32'h00000004);
    rd_reg(8'h30, 32'hFFFFFFFF, 32'h00000000);
    alu(8'h00, 8'h45, 8'h38, OP_ADC, 8'h7D, 2'b10);
    rd_reg(OFS_STATUS, 32'h00000002, 32'h00000002);
    alu(8'h00, 8'hFF, 8'h01, OP_ADC, 8'h00, 2'b11);
    alu(8'h08, 8'h45, 8'h38, OP_ADC, 8'h83, 2'b10);
    rd_reg(OFS_STATUS, 32'h00000002, 32'h00000000);
    alu(8'h08, 8'h58, 8'h47, OP_ADC, 8'h05, 2'b11);
    alu(8'h09, 8'h99, 8'h01, OP_ADC, 8'h01, 2'b11);
    alu(8'h09, 8'h42, 8'h15, OP_SUBTRACT_WITH_BORROW, 8'h27, 2'b11);
    alu(8'h09, 8'h15, 8'h42, OP_SUBTRACT_WITH_BORROW, 8'h73, 2'b10);
    alu(8'h01, 8'h42, 8'h15, OP_SUBTRACT_WITH_BORROW, 8'h2D, 2'b11);
    alu(8'h00, 8'hCA, 8'h0F, OP_AND, 8'h0A, 2'b00);
    alu(8'h00, 8'hCA, 8'h0F, OP_ORA, 8'hCF, 2'b00);
    alu(8'h08, 8'hCA, 8'h0F, OP_EOR, 8'hC5, 2'b00);
    // indexed destination leaves the accumulator alone
    wr_reg(OFS_FLAGS, 8'h20);
    wr_reg(OFS_INDEX, 8'h03);
    wr_reg(OFS_MEM + 8'h0C, 8'h10);
    wr_reg(OFS_OPND, 8'h05);
    wr_reg(OFS_ACC, 8'h77);
    run(OP_ADC, 10);
    rd_reg(OFS_MEM + 8'h0C, 32'h000000FF, 32'h00000015);
    rd_reg(OFS_ACC, 32'h000000FF, 32'h00000077);
    wr_reg(OFS_ACC, 8'h12);
    wr_reg(OFS_OPND, 8'h34);
    wr_reg(OFS_FLAGS, 8'h2B);
    run(OP_PRODUCT, 30);
    rd_reg(OFS_ACC, 32'h000000FF, 32'h000000A8);
    rd_reg(OFS_HIGH, 32'h000000FF, 32'h00000003);
    rd_reg(OFS_FLAGS, 32'h000000FF, 32'h0000002B);
    wr_reg(OFS_ACC, 8'h64);
    wr_reg(OFS_OPND, 8'h07);
    run(OP_DIV, 32);
    rd_reg(OFS_ACC, 32'h000000FF, 32'h0000000E);
    rd_reg(OFS_HIGH, 32'h000000FF, 32'h00000002);
    rd_reg(OFS_FLAGS, 32'h000000FF, 32'h0000002B);
    wr_reg(OFS_OPND, 8'h00);
    run(OP_DIV, 32);
    rd_reg(OFS_ACC, 32'h000000FF, 32'h000000FF);
    rd_reg(OFS_HIGH, 32'h000000FF, 32'h0000000E);
    rd_reg(OFS_FLAGS, 32'h000000FF, 32'h0000002B);
    // every flag set and clear op, from the opposite state
    for (int i = 0; i < 8; i++) begin
      fl = i[0] ? 8'hFF : 8'h00;
      wr_reg(OFS_FLAGS, fl);
      run(cfs_op_e'(4'h6 + i[3:0]), 4);
      rd_reg(OFS_FLAGS, 32'h000000FF, {24'h0, fl ^ (8'h01 << fb[i / 2])});
    end
    // request write stays pending until an instruction completes
    wr_reg(OFS_IRQREQ, 8'h5A);
    @(posedge clk);
    chk({24'h0, irq_req}, 32'h00000000);
    rd_reg(OFS_IRQREQ, 32'h000000FF, 32'h00000000);
    run(OP_NOP, 4);
    chk({24'h0, irq_req}, 32'h0000005A);
    irq_evt <= 8'h81;
    repeat (4) @(posedge clk);
    irq_evt <= 8'h00;
    repeat (2) @(posedge clk);
    chk({24'h0, irq_req}, 32'h000000DB);
    wr_reg(OFS_IRQREQ, 8'h00);
    @(posedge clk);
    chk({24'h0, irq_req}, 32'h000000DB);
    run(OP_NOP, 4);
    chk({24'h0, irq_req}, 32'h00000000);
    // a launch while busy is refused and leaves the carry alone
    wr_reg(OFS_CMD, {4'h0, OP_PRODUCT});
    wr_reg(OFS_CMD, {4'h0, OP_CLEAR_CARRY});
    rd_reg(OFS_STATUS, 32'h00000005, 32'h00000005);
    rd_reg(OFS_CMD, 32'h0000000F, {28'h0, OP_PRODUCT});
    // six bus cycles of the thirty have passed before the count starts
    wait_idle(24);
    rd_reg(OFS_FLAGS, 32'h00000001, 32'h00000001);
    wr_reg(OFS_STATUS, 8'h04);
    rd_reg(OFS_STATUS, 32'h00000005, 32'h00000000);
    summarize;
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    summarize;
  end
endmodule
